// ### rtl/cfgm_pkg.sv
package cfgm_pkg;
	// Register offsets on the serial-port register bus
	localparam logic [4:0] ADDR_CLK_MODE = 5'h01;
	localparam logic [4:0] ADDR_PWR_DOWN = 5'h02;
	localparam logic [4:0] ADDR_RX_A_PD = 5'h03;
	localparam logic [4:0] ADDR_RX_B_PD = 5'h04;
	localparam logic [4:0] ADDR_RX_BIAS_PD = 5'h05;
	localparam int NUM_REGS = 5;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Control flops after reset: standard clocking decoded, Tx clocked, band gap up
	localparam logic [23:0] OUT_RESET = 24'h804008;
	// Clock mode register fields
	localparam int CLK_MODE_MSB = 7;
	localparam int CLK_MODE_LSB = 5;
	localparam int CLKOUT_EN_BIT = 2;
	localparam int CLK_INV_BIT = 1;
	// Power-down register fields
	localparam int TX_PD_MSB = 7;
	localparam int TX_PD_LSB = 5;
	localparam int TX_DIG_PD_BIT = 4;
	localparam int RX_DIG_PD_BIT = 3;
	localparam int PLL_PD_BIT = 2;
	localparam int PLL_DISC_BIT = 1;
	// Receive power-down fields
	localparam int RX_ANA_PD_BIT = 7;
	localparam int RX_DCB_PD_BIT = 6;
	localparam int RX_BIAS_PD_BIT = 7;
	// Transmit output power-down patterns
	localparam logic [2:0] TX_PD_A = 3'h4;
	localparam logic [2:0] TX_PD_B = 3'h2;
	localparam logic [2:0] TX_PD_AB = 3'h7;
	localparam int TX_W = 12;
	// Interface clocking modes
	typedef enum logic [2:0] {
		MODE_STD = 3'b000,
		MODE_FD_OPT = 3'b001,
		MODE_UNUSED2 = 3'b010,
		MODE_HD_WIDE = 3'b011,
		MODE_UNUSED4 = 3'b100,
		MODE_HD_NARROW = 3'b101,
		MODE_UNUSED6 = 3'b110,
		MODE_CLONE = 3'b111
	} cfgm_clk_mode_t;
endpackage : cfgm_pkg

// ### rtl/cfgm_mode_decode.sv
`timescale 1ns/100ps
module cfgm_mode_decode (
	input wire logic [2:0] mode_bits_i,
	output cfgm_pkg::cfgm_clk_mode_t mode_o,
	output logic std_o,
	output logic fd_opt_o,
	output logic hd_wide_o,
	output logic hd_narrow_o,
	output logic clone_o,
	output logic unused_o
);
	////////////////////////////////////////////////////////////
	// Pure decode; the caller registers every result
	always_comb begin
		mode_o = cfgm_pkg::cfgm_clk_mode_t'(mode_bits_i);
		std_o = 1'b0;
		fd_opt_o = 1'b0;
		hd_wide_o = 1'b0;
		hd_narrow_o = 1'b0;
		clone_o = 1'b0;
		unused_o = 1'b0;
		case (mode_o)
			cfgm_pkg::MODE_STD: std_o = 1'b1; // R2
			cfgm_pkg::MODE_FD_OPT: fd_opt_o = 1'b1; // R2
			cfgm_pkg::MODE_HD_WIDE: hd_wide_o = 1'b1; // R1
			cfgm_pkg::MODE_HD_NARROW: hd_narrow_o = 1'b1; // R1
			cfgm_pkg::MODE_CLONE: clone_o = 1'b1; // R1
			default: unused_o = 1'b1; // R1
		endcase
	end
endmodule : cfgm_mode_decode

// ### rtl/cfgm_tx_hold.sv
`timescale 1ns/100ps
module cfgm_tx_hold (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic run_i,
	input wire logic upd_i,
	input wire logic [cfgm_pkg::TX_W-1:0] data_i,
	output logic [cfgm_pkg::TX_W-1:0] data_o
);
	logic [cfgm_pkg::TX_W-1:0] data_r;
	logic [cfgm_pkg::TX_W-1:0] data_nxt;

	////////////////////////////////////////////////////////////
	// Output freezes at its last update while the path is gated
	always_comb begin
		data_nxt = data_r;
		if (run_i && upd_i) begin
			data_nxt = data_i; // R8
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			data_r <= '0;
		end else begin
			data_r <= data_nxt;
		end
	end

	assign data_o = data_r;
endmodule : cfgm_tx_hold

// ### rtl/cfgm_config.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1 - Clock mode 011/101/111 wide/narrow/clone, others unused
// R2 - Mode 000 standard default, 001 optional full-duplex
// R3 - Clock-out enable makes second pin clock output
// R4 - Same bit inverts that clock in full duplex
// R5 - Invert bit inverts third pin output clock
// R6 - Tx pattern 100 A, 010 B, 111 both off
// R7 - Tx digital power-down bit stops Tx clocking
// R8 - Gated Tx outputs hold last update value
// R9 - Rx digital power-down; unused digital auto down
// R10 - PLL power-down bit holds multiplier powered down
// R11 - Bypassed PLL needs fastest Tx clock externally
// R12 - Disconnect removes PLL output; PLL keeps locking
// R13 - Rx analog power-down per channel; bandgap stays
// R14 - Per-channel input bias off; default self-biased
// R15 - Rx bias bit powers all receive bias down
// R16 - Reset clears all power-down and clock bits
module cfgm_config (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic full_duplex_mode_i,
	input wire logic tx_upd_i,
	input wire logic [cfgm_pkg::TX_W-1:0] tx_a_data_i,
	input wire logic [cfgm_pkg::TX_W-1:0] tx_b_data_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic [2:0] clk_mode_o,
	output logic std_clk_mode_o,
	output logic fd_opt_mode_o,
	output logic half_duplex_wide_mode_o,
	output logic half_duplex_narrow_mode_o,
	output logic clone_mode_o,
	output logic unused_mode_o,
	output logic second_interface_pin_clk_en_o,
	output logic second_interface_pin_clk_inv_o,
	output logic third_interface_pin_clk_inv_o,
	output logic tx_a_out_off_o,
	output logic tx_b_out_off_o,
	output logic tx_dig_clk_en_o,
	output logic rx_dig_pd_o,
	output logic pll_pd_o,
	output logic pll_out_disc_o,
	output logic rx_a_analog_pd_o,
	output logic rx_b_analog_pd_o,
	output logic rx_a_bias_off_o,
	output logic rx_b_bias_off_o,
	output logic rx_bias_all_pd_o,
	output logic bandgap_on_o,
	output logic [cfgm_pkg::TX_W-1:0] tx_a_o,
	output logic [cfgm_pkg::TX_W-1:0] tx_b_o
);
	// Register indices: 0 clock mode, 1 power-down, 2/3 rx a/b, 4 rx bias
	logic [7:0] regs_r [cfgm_pkg::NUM_REGS];
	logic [7:0] regs_nxt [cfgm_pkg::NUM_REGS];
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic [2:0] idx;
	logic hit;
	cfgm_pkg::cfgm_clk_mode_t mode_dec;
	logic dec_std;
	logic dec_fd;
	logic dec_wide;
	logic dec_narrow;
	logic dec_clone;
	logic dec_unused;
	logic [23:0] out_r;
	logic [23:0] out_nxt;
	logic [2:0] tx_pd;

	////////////////////////////////////////////////////////////
	// Address decode; unmapped offsets ignore writes, read zero
	function automatic logic [3:0] addr_decode(input logic [4:0] a);
		if (a == cfgm_pkg::ADDR_CLK_MODE) begin
			return 4'h8;
		end else if (a == cfgm_pkg::ADDR_PWR_DOWN) begin
			return 4'h9;
		end else if (a == cfgm_pkg::ADDR_RX_A_PD) begin
			return 4'hA;
		end else if (a == cfgm_pkg::ADDR_RX_B_PD) begin
			return 4'hB;
		end else if (a == cfgm_pkg::ADDR_RX_BIAS_PD) begin
			return 4'hC;
		end else begin
			return 4'h0;
		end
	endfunction : addr_decode

	assign hit = addr_decode(reg_addr_i) != 4'h0;
	assign idx = addr_decode(reg_addr_i) - 4'h8 > 4'h7 ? 3'h0 : 3'(addr_decode(reg_addr_i) - 4'h8);

	////////////////////////////////////////////////////////////
	// Register file and read port
	always_comb begin
		regs_nxt = regs_r;
		rdata_nxt = 8'h00;
		rvalid_nxt = reg_rd_i;
		if (reg_wr_i && hit) begin
			regs_nxt[idx] = reg_wdata_i;
		end
		if (reg_rd_i && hit) begin
			rdata_nxt = regs_r[idx];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < cfgm_pkg::NUM_REGS; i++) begin
				regs_r[i] <= cfgm_pkg::REG_RESET; // R16
			end
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			regs_r <= regs_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	////////////////////////////////////////////////////////////
	cfgm_mode_decode u_mode_decode (
		.mode_bits_i(regs_r[0][cfgm_pkg::CLK_MODE_MSB:cfgm_pkg::CLK_MODE_LSB]),
		.mode_o(mode_dec),
		.std_o(dec_std),
		.fd_opt_o(dec_fd),
		.hd_wide_o(dec_wide),
		.hd_narrow_o(dec_narrow),
		.clone_o(dec_clone),
		.unused_o(dec_unused)
	);

	assign tx_pd = regs_r[1][cfgm_pkg::TX_PD_MSB:cfgm_pkg::TX_PD_LSB];

	////////////////////////////////////////////////////////////
	// Control outputs, registered one cycle after the register
	always_comb begin
		out_nxt[2:0] = mode_dec; // R1
		out_nxt[3] = dec_std; // R2
		out_nxt[4] = dec_fd; // R2
		out_nxt[5] = dec_wide; // R1
		out_nxt[6] = dec_narrow; // R1
		out_nxt[7] = dec_clone; // R1
		out_nxt[8] = dec_unused; // R1
		out_nxt[9] = regs_r[0][cfgm_pkg::CLKOUT_EN_BIT]; // R3
		// Inversion only applies in full duplex
		out_nxt[10] = regs_r[0][cfgm_pkg::CLKOUT_EN_BIT] & full_duplex_mode_i; // R4
		out_nxt[11] = regs_r[0][cfgm_pkg::CLK_INV_BIT]; // R5
		// Other patterns leave both outputs running
		out_nxt[12] = tx_pd == cfgm_pkg::TX_PD_A || tx_pd == cfgm_pkg::TX_PD_AB; // R6
		out_nxt[13] = tx_pd == cfgm_pkg::TX_PD_B || tx_pd == cfgm_pkg::TX_PD_AB; // R6
		out_nxt[14] = ~regs_r[1][cfgm_pkg::TX_DIG_PD_BIT]; // R7
		// Rx digital also drops when neither channel is in use
		out_nxt[15] = regs_r[1][cfgm_pkg::RX_DIG_PD_BIT]
			| (regs_r[2][cfgm_pkg::RX_ANA_PD_BIT] & regs_r[3][cfgm_pkg::RX_ANA_PD_BIT]); // R9
		// Bypass relies on an external clock on the second input
		out_nxt[16] = regs_r[1][cfgm_pkg::PLL_PD_BIT]; // R10 R11
		// Only the path is cut; the PLL keeps tracking
		out_nxt[17] = regs_r[1][cfgm_pkg::PLL_DISC_BIT]; // R12
		out_nxt[18] = regs_r[2][cfgm_pkg::RX_ANA_PD_BIT]; // R13
		out_nxt[19] = regs_r[3][cfgm_pkg::RX_ANA_PD_BIT]; // R13
		out_nxt[20] = regs_r[2][cfgm_pkg::RX_DCB_PD_BIT]; // R14
		out_nxt[21] = regs_r[3][cfgm_pkg::RX_DCB_PD_BIT]; // R14
		out_nxt[22] = regs_r[4][cfgm_pkg::RX_BIAS_PD_BIT]; // R15
		out_nxt[23] = 1'b1; // R13
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			out_r <= cfgm_pkg::OUT_RESET; // R16
		end else begin
			out_r <= out_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign clk_mode_o = out_r[2:0];
	assign std_clk_mode_o = out_r[3];
	assign fd_opt_mode_o = out_r[4];
	assign half_duplex_wide_mode_o = out_r[5];
	assign half_duplex_narrow_mode_o = out_r[6];
	assign clone_mode_o = out_r[7];
	assign unused_mode_o = out_r[8];
	assign second_interface_pin_clk_en_o = out_r[9];
	assign second_interface_pin_clk_inv_o = out_r[10];
	assign third_interface_pin_clk_inv_o = out_r[11];
	assign tx_a_out_off_o = out_r[12];
	assign tx_b_out_off_o = out_r[13];
	assign tx_dig_clk_en_o = out_r[14];
	assign rx_dig_pd_o = out_r[15];
	assign pll_pd_o = out_r[16];
	assign pll_out_disc_o = out_r[17];
	assign rx_a_analog_pd_o = out_r[18];
	assign rx_b_analog_pd_o = out_r[19];
	assign rx_a_bias_off_o = out_r[20];
	assign rx_b_bias_off_o = out_r[21];
	assign rx_bias_all_pd_o = out_r[22];
	// Channel power-down never touches the band gap
	assign bandgap_on_o = out_r[23]; // R13

	////////////////////////////////////////////////////////////
	// Transmit data holders, frozen while the Tx path is gated
	cfgm_tx_hold u_hold_a (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.run_i(out_r[14]),
		.upd_i(tx_upd_i),
		.data_i(tx_a_data_i),
		.data_o(tx_a_o)
	);

	cfgm_tx_hold u_hold_b (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.run_i(out_r[14]),
		.upd_i(tx_upd_i),
		.data_i(tx_b_data_i),
		.data_o(tx_b_o)
	);

	////////////////////////////////////////////////////////////
	// Checks: a write shows at the outputs two edges later
	logic wr_clk;
	logic wr_pd;
	logic wr_ra;
	logic wr_rb;
	logic wr_bias;
	assign wr_clk = reg_wr_i && reg_addr_i == cfgm_pkg::ADDR_CLK_MODE;
	assign wr_pd = reg_wr_i && reg_addr_i == cfgm_pkg::ADDR_PWR_DOWN;
	assign wr_ra = reg_wr_i && reg_addr_i == cfgm_pkg::ADDR_RX_A_PD;
	assign wr_rb = reg_wr_i && reg_addr_i == cfgm_pkg::ADDR_RX_B_PD;
	assign wr_bias = reg_wr_i && reg_addr_i == cfgm_pkg::ADDR_RX_BIAS_PD;

	property p_mode_sel; // R1
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_clk ##1 !wr_clk |=> clone_mode_o == ($past(reg_wdata_i, 2) >> 5 == 8'h07)
			&& half_duplex_wide_mode_o == ($past(reg_wdata_i, 2) >> 5 == 8'h03);
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("clock mode decode wrong"); // R1

	property p_mode_std; // R2
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		std_clk_mode_o |-> clk_mode_o == 3'h0 && !fd_opt_mode_o && !unused_mode_o;
	endproperty
	a_mode_std: assert property (p_mode_std) else $error("standard mode flag wrong"); // R2

	property p_clk_en; // R3
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_clk ##1 !wr_clk |=> second_interface_pin_clk_en_o == $past(reg_wdata_i[2], 2);
	endproperty
	a_clk_en: assert property (p_clk_en) else $error("second pin clock enable wrong"); // R3

	property p_clk_inv2; // R4
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		second_interface_pin_clk_inv_o |-> second_interface_pin_clk_en_o && $past(full_duplex_mode_i);
	endproperty
	a_clk_inv2: assert property (p_clk_inv2) else $error("second pin inversion outside full duplex"); // R4

	property p_clk_inv3; // R5
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_clk ##1 !wr_clk |=> third_interface_pin_clk_inv_o == $past(reg_wdata_i[1], 2);
	endproperty
	a_clk_inv3: assert property (p_clk_inv3) else $error("third pin inversion wrong"); // R5

	property p_tx_pd; // R6
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_pd && reg_wdata_i[7:5] == 3'h4 ##1 !wr_pd |=> tx_a_out_off_o && !tx_b_out_off_o;
	endproperty
	a_tx_pd: assert property (p_tx_pd) else $error("tx A power-down decode wrong"); // R6

	property p_tx_gate; // R7
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_pd ##1 !wr_pd |=> tx_dig_clk_en_o == !$past(reg_wdata_i[4], 2);
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx digital gate wrong"); // R7

	property p_tx_hold; // R8
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		!tx_dig_clk_en_o |=> $stable(tx_a_o) && $stable(tx_b_o);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx output moved while gated"); // R8

	property p_rx_dig; // R9
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		rx_a_analog_pd_o && rx_b_analog_pd_o |-> rx_dig_pd_o;
	endproperty
	a_rx_dig: assert property (p_rx_dig) else $error("rx digital not powered down"); // R9

	property p_pll; // R10
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_pd ##1 !wr_pd |=> pll_pd_o == $past(reg_wdata_i[2], 2);
	endproperty
	a_pll: assert property (p_pll) else $error("pll power-down wrong"); // R10

	property p_pll_disc; // R12
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_pd ##1 !wr_pd |=> pll_out_disc_o == $past(reg_wdata_i[1], 2);
	endproperty
	a_pll_disc: assert property (p_pll_disc) else $error("pll disconnect wrong"); // R12

	property p_rx_ana; // R13
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_ra ##1 !wr_ra |=> rx_a_analog_pd_o == $past(reg_wdata_i[7], 2) && bandgap_on_o;
	endproperty
	a_rx_ana: assert property (p_rx_ana) else $error("rx A analog power-down wrong"); // R13

	property p_rx_dcb; // R14
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_rb ##1 !wr_rb |=> rx_b_bias_off_o == $past(reg_wdata_i[6], 2);
	endproperty
	a_rx_dcb: assert property (p_rx_dcb) else $error("rx B input bias wrong"); // R14

	property p_rx_bias; // R15
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_bias ##1 !wr_bias |=> rx_bias_all_pd_o == $past(reg_wdata_i[7], 2);
	endproperty
	a_rx_bias: assert property (p_rx_bias) else $error("rx bias power-down wrong"); // R15

	property p_reset; // R16
		@(posedge clk_sys_i)
		!reset_n_i |=> out_r == cfgm_pkg::OUT_RESET && regs_r[1] == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong"); // R16
endmodule : cfgm_config

// ### tb/cfgm_host_model.sv
`timescale 1ns/100ps
// Host that programs the configuration registers, one strobe per access
module cfgm_host_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_rvalid_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [4:0] reg_addr_o,
	output logic [7:0] reg_wdata_o
);
	// Idle bus from time zero
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 5'h00;
		reg_wdata_o = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Write strobe held for one edge; idle lines then scrambled so stale data never looks valid
	task automatic wr(input logic [4:0] addr, input logic [7:0] data);
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= addr;
		reg_wdata_o <= data;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~addr;
		reg_wdata_o <= ~data;
	endtask : wr

	// Read answer is fixed one cycle after the strobe edge
	task automatic rd(input logic [4:0] addr, output logic [7:0] data, output logic ok);
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= addr;
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~addr;
		#1;
		data = reg_rdata_i;
		ok = reg_rvalid_i;
	endtask : rd
endmodule : cfgm_host_model

// ### tb/clock_and_power_down_config_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the clock and power-down configuration block
module clock_and_power_down_config_tb_top;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic fd = 1'b0;
	logic tx_upd = 1'b0;
	logic [cfgm_pkg::TX_W-1:0] txa_d = '0;
	logic [cfgm_pkg::TX_W-1:0] txb_d = '0;
	logic [cfgm_pkg::TX_W-1:0] txa, txb;
	logic reg_wr, reg_rd, rvalid, rd_ok;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, rd_v;
	logic [2:0] mode;
	logic std, fdo, hdw, hdn, clone, unused, s2en, s2inv, s3inv, aoff, boff, txen;
	logic rxdig, pllpd, plldisc, rxaa, rxba, rxab, rxbb, rxall, bgap;
	int error_cnt = 0;
	int compares = 0;

	// 100 MHz system clock
	always #5 clk_sys_i = ~clk_sys_i;

	cfgm_host_model u_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
		.reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

	cfgm_config DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .full_duplex_mode_i(fd), .tx_upd_i(tx_upd),
		.tx_a_data_i(txa_d), .tx_b_data_i(txb_d), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.clk_mode_o(mode), .std_clk_mode_o(std), .fd_opt_mode_o(fdo), .half_duplex_wide_mode_o(hdw),
		.half_duplex_narrow_mode_o(hdn), .clone_mode_o(clone), .unused_mode_o(unused),
		.second_interface_pin_clk_en_o(s2en), .second_interface_pin_clk_inv_o(s2inv),
		.third_interface_pin_clk_inv_o(s3inv), .tx_a_out_off_o(aoff), .tx_b_out_off_o(boff),
		.tx_dig_clk_en_o(txen), .rx_dig_pd_o(rxdig), .pll_pd_o(pllpd), .pll_out_disc_o(plldisc),
		.rx_a_analog_pd_o(rxaa), .rx_b_analog_pd_o(rxba), .rx_a_bias_off_o(rxab), .rx_b_bias_off_o(rxbb),
		.rx_bias_all_pd_o(rxall), .bandgap_on_o(bgap), .tx_a_o(txa), .tx_b_o(txb));

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		if (error_cnt == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Control outputs lag the write edge by one more edge
	task automatic wr_settle(input logic [4:0] a, input logic [7:0] d);
		u_host.wr(a, d);
		@(posedge clk_sys_i);
		#1;
	endtask : wr_settle

	task automatic tx_send(input logic [cfgm_pkg::TX_W-1:0] a, input logic [cfgm_pkg::TX_W-1:0] b);
		@(posedge clk_sys_i);
		tx_upd <= 1'b1;
		txa_d <= a;
		txb_d <= b;
		@(posedge clk_sys_i);
		tx_upd <= 1'b0;
		#1;
	endtask : tx_send

	function automatic logic [5:0] mode_exp(input logic [2:0] m);
		case (m)
			3'h0: mode_exp = 6'h20;
			3'h1: mode_exp = 6'h10;
			3'h3: mode_exp = 6'h08;
			3'h5: mode_exp = 6'h04;
			3'h7: mode_exp = 6'h02;
			default: mode_exp = 6'h01;
		endcase
	endfunction : mode_exp

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		@(posedge clk_sys_i);
		reset_n_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		#1;
		check({txen, std, bgap}, 32'h7);
		check({mode, fdo, hdw, hdn, clone, unused, s2en, s2inv, s3inv, aoff, boff, rxdig, pllpd, plldisc,
			rxaa, rxba, rxab, rxbb, rxall}, 32'h0);
		for (int a = 1; a <= 5; a++) begin
			u_host.rd(5'(a), rd_v, rd_ok);
			check({rd_ok, rd_v}, 32'h100);
		end
	endtask : t_reset

	task automatic t_modes();
		for (int m = 0; m < 8; m++) begin
			wr_settle(cfgm_pkg::ADDR_CLK_MODE, {3'(m), 5'h00});
			check({std, fdo, hdw, hdn, clone, unused}, mode_exp(3'(m)));
			check(mode, m);
		end
	endtask : t_modes

	// Output clock enable and inversions, with and without full duplex
	task automatic t_clkout();
		for (int f = 0; f < 2; f++) begin
			@(posedge clk_sys_i);
			fd <= f[0];
			wr_settle(cfgm_pkg::ADDR_CLK_MODE, 8'h04);
			check({s2en, s3inv}, 32'h2);
			check(s2inv, f);
			wr_settle(cfgm_pkg::ADDR_CLK_MODE, 8'h02);
			check({s2en, s2inv, s3inv}, 32'h1);
		end
	endtask : t_clkout

	task automatic t_txpd();
		for (int p = 0; p < 8; p++) begin
			wr_settle(cfgm_pkg::ADDR_PWR_DOWN, {3'(p), 5'h00});
			check({aoff, boff}, {(p == 4 || p == 7), (p == 2 || p == 7)});
			check(txen, 32'h1);
		end
	endtask : t_txpd

	// Gated transmit path must ignore updates and keep old samples
	task automatic t_txhold();
		wr_settle(cfgm_pkg::ADDR_PWR_DOWN, 8'h00);
		tx_send(12'h123, 12'h456);
		check({txa, txb}, 32'h123456);
		wr_settle(cfgm_pkg::ADDR_PWR_DOWN, 8'h10);
		check(txen, 32'h0);
		tx_send(12'hABC, 12'hDEF);
		repeat (3) @(posedge clk_sys_i);
		check({txa, txb}, 32'h123456);
		wr_settle(cfgm_pkg::ADDR_PWR_DOWN, 8'h00);
		tx_send(12'hABC, 12'hDEF);
		check({txa, txb}, 32'hABCDEF);
	endtask : t_txhold

	task automatic t_pwr();
		for (int i = 1; i <= 3; i++) begin
			wr_settle(cfgm_pkg::ADDR_PWR_DOWN, 8'h01 << i);
			check({rxdig, pllpd, plldisc}, 3'h1 << (i - 1));
		end
		wr_settle(cfgm_pkg::ADDR_PWR_DOWN, 8'h00);
		wr_settle(cfgm_pkg::ADDR_RX_A_PD, 8'h80);
		check({rxdig, rxaa, rxba}, 32'h2);
		wr_settle(cfgm_pkg::ADDR_RX_B_PD, 8'h80);
		check({rxdig, rxaa, rxba, bgap}, 32'hF);
		wr_settle(cfgm_pkg::ADDR_RX_A_PD, 8'h40);
		wr_settle(cfgm_pkg::ADDR_RX_B_PD, 8'h00);
		check({rxaa, rxba, rxab, rxbb}, 32'h2);
		wr_settle(cfgm_pkg::ADDR_RX_B_PD, 8'h40);
		check({rxab, rxbb, rxall}, 32'h6);
		wr_settle(cfgm_pkg::ADDR_RX_BIAS_PD, 8'h80);
		check(rxall, 32'h1);
		wr_settle(cfgm_pkg::ADDR_RX_BIAS_PD, 8'h7F);
		check({rxall, bgap}, 32'h1);
	endtask : t_pwr

	// Back-to-back write and read, plus unmapped offsets
	task automatic t_readback();
		for (int a = 1; a <= 5; a++) begin
			u_host.wr(5'(a), 8'hA0 + 8'(a));
			u_host.rd(5'(a), rd_v, rd_ok);
			check({rd_ok, rd_v}, 32'h1A0 + a);
		end
		u_host.wr(5'h06, 8'hFF);
		u_host.wr(5'h00, 8'hFF);
		u_host.rd(5'h06, rd_v, rd_ok);
		check({rd_ok, rd_v}, 32'h100);
		u_host.rd(cfgm_pkg::ADDR_CLK_MODE, rd_v, rd_ok);
		check(rd_v, 32'hA1);
	endtask : t_readback

	////////////////////////////////////////////////////////////////////////
	// Main sequence, ending with a mid-run reset
	initial begin
		t_reset();
		t_modes();
		t_clkout();
		t_txpd();
		t_txhold();
		t_pwr();
		t_readback();
		t_reset();
		tally_and_finish();
	end

	// Hang guard well above the longest sequence
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		error_cnt++;
		tally_and_finish();
	end
endmodule : clock_and_power_down_config_tb_top
